// ==== rtl/trunk_data_module.sv ====
// Option-controlled call, framing and lead-routing logic of the trunk data module.
//
// Functional notes
// (R1) Triple break from terminal tears down call when enabled; ignored when disabled.
// (R2) Two seconds continuous spacing ends call when enabled; ignored with dial-network modems.
// (R3) ASCII keypad dialing accepted only while its option is on.
// (R4) Parity selectors: on/off even, on/on odd, off/off zero, off/on one.
// (R5) Modem class selector: on means dial-network modems, off leased line modems.
// (R6) Loss of received line signal ends call only when its option is on.
// (R7) CN and TM may each reach position 25, never both together.
// (R8) Secondary CI reaches position 13 only with dial-network class and option on.
// (R9) CI reaches position 12 only while its routing option is on.
// (R10) CN reaches position 18 only while its routing option is on.
// (R11) CH reaches position 23 only while its routing option is on.
// (R12) RL reaches position 21 only while its routing option is on.
// (R13) Secondary CH reaches position 19 only while its routing option is on.
// (R14) Selectors pick half duplex, clocked framing, external timing when on.
// (R15) 64 kb/s forces clocked framing, local timing and full duplex.
// (R16) 56 kb/s forces clocked framing and external timing.
// (R17) Both ends use the highest rate enabled at both ends.
`timescale 1ns/1ps
module trunk_data_module
    import trunk_data_pkg::*;
#(
    parameter int SpacingCycles = SPACING_CYCLES,
    parameter int BreakCycles = BREAK_CYCLES,
    parameter int BreakGapCycles = BREAK_GAP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Terminal side
    input wire logic termTxd,
    input wire logic termCharValid,
    input wire logic [6:0] termChar,
    output logic parityBit,
    // Switch side
    input wire logic switchAnswer,
    input wire logic [RATE_COUNT-1:0] farRates,
    output logic callActive,
    output logic hangupPulse,
    // Modem side
    input wire logic carrierDetect,
    // Interface circuits to be routed
    input wire logic ciCircuit,
    input wire logic ci2Circuit,
    input wire logic cnCircuit,
    input wire logic tmCircuit,
    input wire logic chCircuit,
    input wire logic ch2Circuit,
    input wire logic rlCircuit,
    // Connector positions, value and drive enable
    output logic pin12,
    output logic pin12Oe,
    output logic pin13,
    output logic pin13Oe,
    output logic pin18,
    output logic pin18Oe,
    output logic pin19,
    output logic pin19Oe,
    output logic pin21,
    output logic pin21Oe,
    output logic pin23,
    output logic pin23Oe,
    output logic pin25,
    output logic pin25Oe,
    // Effective line configuration
    output logic halfDuplex,
    output logic clockedFraming,
    output logic externalTiming,
    output logic [3:0] agreedRate
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic [OPT_WIDTH-1:0] options;
    logic [RATE_COUNT-1:0] rates;
    logic [EV_WIDTH-1:0] events;
    logic [6:0] dialChar;
    logic [7:0] dialCount;
    call_state_t callState;
    logic wrPending;
    logic [7:0] wrAddr;

    wire addrPhase = hsel && hready && htrans[1];
    wire wrOptions = wrPending && (wrAddr == OPTIONS_ADDR);
    wire wrRates = wrPending && (wrAddr == RATES_ADDR);
    wire wrCtrl = wrPending && (wrAddr == CALL_CTRL_ADDR);
    wire wrEvents = wrPending && (wrAddr == EVENTS_ADDR);
    wire [7:0] rdAddr = haddr[7:0];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            wrPending <= addrPhase && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    wire [31:0] statusWord = {16'h0000, 2'b00, callState, agreedRate,
        1'b0, clockedFraming, externalTiming, halfDuplex, 4'h0};
    wire [31:0] next_hrdata =
        (rdAddr == OPTIONS_ADDR) ? {{(32-OPT_WIDTH){1'b0}}, options} :
        (rdAddr == RATES_ADDR) ? {{(32-RATE_COUNT){1'b0}}, rates} :
        (rdAddr == STATUS_ADDR) ? statusWord :
        (rdAddr == EVENTS_ADDR) ? {{(32-EV_WIDTH){1'b0}}, events} :
        (rdAddr == DIAL_ADDR) ? {16'h0000, dialCount, 1'b0, dialChar} : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // Zero wait states keep the master simple; every access answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            options <= OPTIONS_RESET;
            rates <= RATES_RESET;
        end else begin
            if (wrOptions) begin
                options <= hwdata[OPT_WIDTH-1:0];
            end
            if (wrRates) begin
                rates <= hwdata[RATE_COUNT-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Rate agreement and effective framing
    // ------------------------------------------------------------------
    wire [RATE_COUNT-1:0] commonRates = rates & farRates;
    logic [3:0] highestCommon;

    always_comb begin
        highestCommon = RATE_NONE;
        for (int i = 0; i < RATE_COUNT; i++) begin
            if (commonRates[i]) begin
                highestCommon = 4'(i); // R17
            end
        end
    end

    wire at64k = (highestCommon == 4'(RATE_64K));
    wire at56k = (highestCommon == 4'(RATE_56K));
    wire next_halfDuplex = at64k ? 1'b0 : options[OPT_HALF_DUPLEX]; // R14 R15
    wire next_clocked = (at64k || at56k) ? 1'b1 : options[OPT_CLOCKED]; // R14 R15 R16
    wire next_external = at64k ? 1'b0 : (at56k ? 1'b1 : options[OPT_EXT_CLOCK]); // R15 R16

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            agreedRate <= RATE_NONE;
            halfDuplex <= 1'b0;
            clockedFraming <= 1'b0;
            externalTiming <= 1'b0;
        end else begin
            agreedRate <= highestCommon;
            halfDuplex <= next_halfDuplex;
            clockedFraming <= next_clocked;
            externalTiming <= next_external;
        end
    end

    // ------------------------------------------------------------------
    // Parity generation
    // ------------------------------------------------------------------
    wire parityHigh = options[OPT_PARITY_HIGH];
    wire parityLow = options[OPT_PARITY_LOW];
    wire evenBit = ^termChar;
    wire next_parityBit = parityHigh ? (parityLow ? ~evenBit : evenBit) : parityLow; // R4

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            parityBit <= 1'b0;
        end else if (termCharValid) begin
            parityBit <= next_parityBit;
        end
    end

    // ------------------------------------------------------------------
    // Line watchers: spacing, breaks, carrier
    // ------------------------------------------------------------------
    // Spacing is a low terminal transmit line.
    logic [31:0] spaceCount;
    logic [31:0] markCount;
    logic [1:0] breakCount;
    logic breakSeen;

    wire spacing = !termTxd;
    wire connected = (callState == CALL_CONNECTED);
    wire dialNetwork = options[OPT_DIAL_NETWORK]; // R5
    wire spacingLimit = spacing && (spaceCount == 32'(SpacingCycles - 1));
    wire breakLimit = spacing && (spaceCount == 32'(BreakCycles - 1));
    wire gapExpired = !spacing && (markCount >= 32'(BreakGapCycles - 1));

    // The counters saturate so an endless space cannot wrap and retrigger.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            spaceCount <= 32'h0000_0000;
            markCount <= 32'h0000_0000;
        end else begin
            if (!spacing || !connected) begin
                spaceCount <= 32'h0000_0000;
            end else if (spaceCount != 32'hFFFF_FFFF) begin
                spaceCount <= spaceCount + 32'h0000_0001;
            end
            if (spacing || !connected) begin
                markCount <= 32'h0000_0000;
            end else if (!gapExpired) begin
                markCount <= markCount + 32'h0000_0001;
            end
        end
    end

    // A break counts once it returns to mark; a long mark between breaks restarts the count.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            breakSeen <= 1'b0;
            breakCount <= 2'd0;
        end else if (!connected || gapExpired) begin
            breakSeen <= 1'b0;
            breakCount <= 2'd0;
        end else if (breakLimit) begin
            breakSeen <= 1'b1;
        end else if (breakSeen && !spacing) begin
            breakSeen <= 1'b0;
            breakCount <= breakCount + 2'd1;
        end
    end

    wire thirdBreak = breakSeen && !spacing && (breakCount == 2'd2);
    wire tripleHangup = connected && options[OPT_TRIPLE_BREAK] && thirdBreak; // R1
    wire spacingHangup = connected && options[OPT_SPACING_HANGUP] && !dialNetwork
        && spacingLimit; // R2
    wire carrierHangup = connected && options[OPT_CARRIER_HANGUP] && !carrierDetect; // R6
    wire localHangup = wrCtrl && hwdata[CTRL_HANGUP] && (callState != CALL_IDLE);
    wire anyHangup = tripleHangup || spacingHangup || carrierHangup || localHangup;

    // ------------------------------------------------------------------
    // Call state and keypad dialing
    // ------------------------------------------------------------------
    wire originate = wrCtrl && hwdata[CTRL_ORIGINATE] && (callState == CALL_IDLE);
    wire dialTake = termCharValid && (callState == CALL_DIALING);
    wire dialAccept = dialTake && options[OPT_KEYPAD]; // R3
    wire dialRefuse = dialTake && !options[OPT_KEYPAD]; // R3
    wire routeConflict = options[OPT_CN_CIRCUIT_ROUTE_HIGH] && options[OPT_TEST_MODE_CIRCUIT_ROUTE];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            callState <= CALL_IDLE;
        end else if (anyHangup) begin
            callState <= CALL_IDLE;
        end else begin
            unique case (callState)
                CALL_IDLE: begin
                    if (originate) begin
                        callState <= CALL_DIALING;
                    end
                end
                CALL_DIALING: begin
                    if (switchAnswer) begin
                        callState <= CALL_CONNECTED;
                    end
                end
                CALL_CONNECTED: begin
                    callState <= CALL_CONNECTED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dialChar <= 7'h00;
            dialCount <= 8'h00;
        end else if (originate) begin
            dialCount <= 8'h00;
        end else if (dialAccept) begin
            dialChar <= termChar;
            dialCount <= dialCount + 8'h01;
        end
    end

    wire [EV_WIDTH-1:0] eventSet = {dialRefuse, routeConflict, carrierHangup,
        spacingHangup, tripleHangup};
    wire [EV_WIDTH-1:0] eventClear = wrEvents ? hwdata[EV_WIDTH-1:0] : '0;

    // A new event in the clearing cycle survives the write-one-to-clear.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            events <= '0;
            hangupPulse <= 1'b0;
        end else begin
            events <= (events & ~eventClear) | eventSet;
            hangupPulse <= anyHangup;
        end
    end

    assign callActive = connected;

    // ------------------------------------------------------------------
    // Lead routing
    // ------------------------------------------------------------------
    // A conflicting CN/TM setting releases position 25 rather than pick a winner.
    assign pin25Oe = (options[OPT_CN_CIRCUIT_ROUTE_HIGH] ^ options[OPT_TEST_MODE_CIRCUIT_ROUTE]); // R7
    assign pin25 = pin25Oe && (options[OPT_CN_CIRCUIT_ROUTE_HIGH] ? cnCircuit : tmCircuit); // R7
    assign pin13Oe = options[OPT_CI13] && dialNetwork; // R8
    assign pin13 = pin13Oe && ci2Circuit; // R8
    assign pin12Oe = options[OPT_CI12]; // R9
    assign pin12 = pin12Oe && ciCircuit; // R9
    assign pin18Oe = options[OPT_CN18]; // R10
    assign pin18 = pin18Oe && cnCircuit; // R10
    assign pin23Oe = options[OPT_RATE_SELECT_CIRCUIT_ROUTE_A]; // R11
    assign pin23 = pin23Oe && chCircuit; // R11
    assign pin21Oe = options[OPT_REMOTE_LOOP_CIRCUIT_ROUTE]; // R12
    assign pin21 = pin21Oe && rlCircuit; // R12
    assign pin19Oe = options[OPT_RATE_SELECT_CIRCUIT_ROUTE_B]; // R13
    assign pin19 = pin19Oe && ch2Circuit; // R13

endmodule

// ==== rtl/trunk_data_pkg.sv ====
// Shared constants for the trunk data module option block.
package trunk_data_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] OPTIONS_ADDR = 8'h00;
    localparam logic [7:0] RATES_ADDR = 8'h04;
    localparam logic [7:0] CALL_CTRL_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0C;
    localparam logic [7:0] EVENTS_ADDR = 8'h10;
    localparam logic [7:0] DIAL_ADDR = 8'h14;

    // ------------------------------------------------------------------
    // Option register fields
    // ------------------------------------------------------------------
    localparam int OPT_WIDTH = 18;
    localparam int OPT_TRIPLE_BREAK = 0;
    localparam int OPT_HALF_DUPLEX = 1;
    localparam int OPT_CLOCKED = 2;
    localparam int OPT_EXT_CLOCK = 3;
    localparam int OPT_SPACING_HANGUP = 4;
    localparam int OPT_KEYPAD = 5;
    localparam int OPT_PARITY_HIGH = 6;
    localparam int OPT_PARITY_LOW = 7;
    localparam int OPT_DIAL_NETWORK = 8;
    localparam int OPT_CARRIER_HANGUP = 9;
    localparam int OPT_CI12 = 10;
    localparam int OPT_CN_CIRCUIT_ROUTE_HIGH = 11;
    localparam int OPT_TEST_MODE_CIRCUIT_ROUTE = 12;
    localparam int OPT_CI13 = 13;
    localparam int OPT_CN18 = 14;
    localparam int OPT_RATE_SELECT_CIRCUIT_ROUTE_A = 15;
    localparam int OPT_REMOTE_LOOP_CIRCUIT_ROUTE = 16;
    localparam int OPT_RATE_SELECT_CIRCUIT_ROUTE_B = 17;
    localparam logic [OPT_WIDTH-1:0] OPTIONS_RESET = 18'h0_0000;

    // ------------------------------------------------------------------
    // Rates: bit 0 low speed up to bit 8 at 64 kb/s
    // ------------------------------------------------------------------
    localparam int RATE_COUNT = 9;
    localparam int RATE_56K = 7;
    localparam int RATE_64K = 8;
    localparam logic [RATE_COUNT-1:0] RATES_RESET = 9'h000;
    localparam logic [3:0] RATE_NONE = 4'hF;

    // ------------------------------------------------------------------
    // Call control and event bits
    // ------------------------------------------------------------------
    localparam int CTRL_ORIGINATE = 0;
    localparam int CTRL_HANGUP = 1;
    localparam int EV_TRIPLE_BREAK = 0;
    localparam int EV_SPACING = 1;
    localparam int EV_CARRIER = 2;
    localparam int EV_ROUTE_CONFLICT = 3;
    localparam int EV_DIAL_REFUSED = 4;
    localparam int EV_WIDTH = 5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SPACING_HANGUP_S = 2;
    localparam int SPACING_CYCLES = SPACING_HANGUP_S * CLK_HZ;
    localparam int BREAK_MIN_MS = 100;
    localparam int BREAK_CYCLES = BREAK_MIN_MS * (CLK_HZ / 1000);
    localparam int BREAK_GAP_MS = 1000;
    localparam int BREAK_GAP_CYCLES = BREAK_GAP_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        CALL_IDLE,
        CALL_DIALING,
        CALL_CONNECTED
    } call_state_t;

endpackage

// ==== tb/trunk_data_checker.sv ====
// Port-level assertion checker for the trunk data module.
`timescale 1ns/1ps
module trunk_data_checker
    import trunk_data_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Circuits in
    input wire logic ciCircuit,
    input wire logic cnCircuit,
    input wire logic chCircuit,
    input wire logic rlCircuit,
    // Call state
    input wire logic callActive,
    input wire logic hangupPulse,
    // Connector positions
    input wire logic pin12,
    input wire logic pin12Oe,
    input wire logic pin18,
    input wire logic pin18Oe,
    input wire logic pin21,
    input wire logic pin21Oe,
    input wire logic pin23,
    input wire logic pin23Oe,
    input wire logic pin25,
    input wire logic pin25Oe,
    // Line configuration
    input wire logic halfDuplex,
    input wire logic clockedFraming,
    input wire logic externalTiming,
    input wire logic [3:0] agreedRate
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    pin25_release_a: assert property (!pin25Oe |-> !pin25)
        else $error("position 25 carries a level while released");
    pin12_route_a: assert property (pin12 == (pin12Oe & ciCircuit))
        else $error("position 12 does not follow its circuit");
    pin18_route_a: assert property (pin18 == (pin18Oe & cnCircuit))
        else $error("position 18 does not follow its circuit");
    pin23_route_a: assert property ($fell(pin23Oe) |-> !pin23)
        else $error("position 23 still driven after release");
    pin21_route_a: assert property (pin21Oe |-> pin21 == rlCircuit)
        else $error("position 21 does not follow its circuit");
    rate64_force_a: assert property (agreedRate == RATE_64K |->
        clockedFraming && !externalTiming && !halfDuplex)
        else $error("top rate does not force its line setup");
    rate56_force_a: assert property (agreedRate == RATE_56K |->
        clockedFraming && externalTiming)
        else $error("second rate does not force its line setup");
    hangup_pulse_a: assert property (hangupPulse |-> !callActive ##1 !hangupPulse)
        else $error("teardown pulse malformed");

    cover property (hangupPulse);
    cover property (pin25Oe && pin25);
    cover property (agreedRate == RATE_64K);
endmodule

bind trunk_data_module trunk_data_checker trunk_data_checker_inst (.*);

// ==== tb/modem_model.sv ====
// Behavioural modem giving received line signal and far-end rate enables.
`timescale 1ns/1ps
module modem_model (
    // Clock
    input wire logic clk_sys,
    // Commands from the bench
    input wire logic lineUp,
    input wire logic [8:0] rateMask,
    // Modem leads
    output logic carrierDetect,
    output logic [8:0] farRates
);
    initial carrierDetect = 1'b1;
    initial farRates = 9'h000;
    // A real receiver needs time to declare loss, so the lead lags one cycle.
    always @(posedge clk_sys) begin
        carrierDetect <= lineUp;
        farRates <= rateMask;
    end
endmodule

// ==== tb/trunk_data_module_test.sv ====
// Self-checking testbench for the trunk data module.
`timescale 1ns/1ps
module trunk_data_module_test;
    import trunk_data_pkg::*;
    localparam int SpacingCycles = 200;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, parityBit, callActive, hangupPulse, carrierDetect;
    logic halfDuplex, clockedFraming, externalTiming;
    logic termTxd = 1'b1;
    logic termCharValid = 1'b0;
    logic switchAnswer = 1'b0;
    logic lineUp = 1'b1;
    logic [6:0] termChar = 7'h00;
    logic [6:0] circ = 7'h00;
    logic [6:0] pins, oes;
    logic [8:0] rateMask = 9'h000;
    logic [8:0] farRates;
    logic [3:0] agreedRate;
    logic [31:0] rOpt [4] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_000A, 32'h0000_000A};
    logic [8:0] rLoc [4] = '{9'h006, 9'h180, 9'h180, 9'h030};
    logic [8:0] rFar [4] = '{9'h1FF, 9'h0FF, 9'h1FF, 9'h00F};
    logic [6:0] rExp [4] = '{7'h14, 7'h3F, 7'h42, 7'h7D};
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #20 clk_sys = ~clk_sys;

    trunk_data_module #(.SpacingCycles(SpacingCycles), .BreakCycles(20),
        .BreakGapCycles(100)) trunk_data_module_inst (
        .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .termTxd(termTxd),
        .termCharValid(termCharValid), .termChar(termChar), .parityBit(parityBit),
        .switchAnswer(switchAnswer), .farRates(farRates), .callActive(callActive),
        .hangupPulse(hangupPulse), .carrierDetect(carrierDetect),
        .ciCircuit(circ[0]), .ci2Circuit(circ[1]), .cnCircuit(circ[2]),
        .tmCircuit(circ[3]), .chCircuit(circ[4]), .ch2Circuit(circ[5]),
        .rlCircuit(circ[6]), .pin12(pins[0]), .pin12Oe(oes[0]), .pin13(pins[1]),
        .pin13Oe(oes[1]), .pin18(pins[2]), .pin18Oe(oes[2]), .pin19(pins[3]),
        .pin19Oe(oes[3]), .pin21(pins[4]), .pin21Oe(oes[4]), .pin23(pins[5]),
        .pin23Oe(oes[5]), .pin25(pins[6]), .pin25Oe(oes[6]), .halfDuplex(halfDuplex),
        .clockedFraming(clockedFraming), .externalTiming(externalTiming),
        .agreedRate(agreedRate));

    modem_model modem_model_inst (.clk_sys(clk_sys), .lineUp(lineUp), .rateMask(rateMask),
        .carrierDetect(carrierDetect), .farRates(farRates));

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hung handshake or wait must still reach the closing report.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic sendChar(input logic [6:0] c);
        @(posedge clk_sys);
        termChar <= c;
        termCharValid <= 1'b1;
        @(posedge clk_sys);
        termCharValid <= 1'b0;
    endtask

    task automatic space(input int n);
        @(posedge clk_sys);
        termTxd <= 1'b0;
        repeat (n) @(posedge clk_sys);
        termTxd <= 1'b1;
    endtask

    task automatic connect(input logic [31:0] opt);
        xfer(1'b1, OPTIONS_ADDR, opt);
        xfer(1'b1, CALL_CTRL_ADDR, 32'h0000_0001);
        @(posedge clk_sys);
        switchAnswer <= 1'b1;
        @(posedge clk_sys);
        switchAnswer <= 1'b0;
        tick(1);
        chk(callActive, 1);
    endtask

    task automatic endCall(input logic exp, input string s);
        tick(3);
        chk(callActive, exp);
        xfer(1'b1, CALL_CTRL_ADDR, 32'h0000_0002);
        $display("test %s finished", s);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(STATUS_ADDR, 32'h0000_0F00);
        rdchk(8'h20, 32'h0000_0000);
        chk({oes, hresp}, 0);
        $display("test reset finished");
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, OPTIONS_ADDR, 32'(k) << OPT_PARITY_HIGH);
            sendChar(7'h43);
            tick(1);
            chk(parityBit, 1'(4'b0110 >> k));
        end
        $display("test parity finished");
        circ <= 7'h5B;
        xfer(1'b1, OPTIONS_ADDR, 32'h0003_CC00);
        tick(1);
        chk({oes, pins}, {7'h7D, 7'h31});
        xfer(1'b1, OPTIONS_ADDR, 32'h0003_DC00);
        tick(1);
        chk({oes, pins}, {7'h3D, 7'h31});
        rdchk(EVENTS_ADDR, 32'h0000_0008);
        xfer(1'b1, OPTIONS_ADDR, 32'h0000_3000);
        tick(1);
        chk({oes, pins}, {7'h40, 7'h40});
        xfer(1'b1, OPTIONS_ADDR, 32'h0000_3100);
        tick(1);
        chk({oes, pins}, {7'h42, 7'h42});
        $display("test routing finished");
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, OPTIONS_ADDR, rOpt[i]);
            xfer(1'b1, RATES_ADDR, 32'(rLoc[i]));
            @(posedge clk_sys);
            rateMask <= rFar[i];
            tick(3);
            chk({agreedRate, halfDuplex, clockedFraming, externalTiming}, rExp[i]);
        end
        $display("test rates finished");
        xfer(1'b1, OPTIONS_ADDR, 32'h0000_0020);
        xfer(1'b1, CALL_CTRL_ADDR, 32'h0000_0001);
        sendChar(7'h35);
        rdchk(DIAL_ADDR, 32'h0000_0135);
        xfer(1'b1, OPTIONS_ADDR, 32'h0000_0000);
        xfer(1'b1, CALL_CTRL_ADDR, 32'h0000_0002);
        xfer(1'b1, CALL_CTRL_ADDR, 32'h0000_0001);
        sendChar(7'h36);
        rdchk(DIAL_ADDR, 32'h0000_0035);
        xfer(1'b0, EVENTS_ADDR, 32'h0000_0000);
        chk(rd[EV_DIAL_REFUSED], 1);
        endCall(0, "keypad");
        for (int e = 0; e < 2; e++) begin
            connect(32'(e) << OPT_CARRIER_HANGUP);
            @(posedge clk_sys);
            lineUp <= 1'b0;
            tick(2);
            lineUp <= 1'b1;
            endCall(e == 0, "carrier");
        end
        for (int e = 0; e < 3; e++) begin
            connect(e == 0 ? 32'h0000_0010 : (e == 1 ? 32'h0000_0110 : 32'h0000_0000));
            space(SpacingCycles + 20);
            endCall(e != 0, "spacing");
        end
        for (int e = 0; e < 2; e++) begin
            connect(32'(e));
            repeat (3) begin
                space(30);
                repeat (10) @(posedge clk_sys);
            end
            endCall(e == 0, "triple break");
        end
        summarize();
    end
endmodule
